// [verilog/adcfmt_pkg.sv]
// Package of constants shared by the output data formatter
package adcfmt_pkg;
	// APB register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	// Control field positions
	localparam int CTRL_INTERFACE_BIT = 0;
	localparam int CTRL_FORMAT_BIT = 1;
	localparam int CTRL_PDN_BIT = 2;
	localparam int CTRL_PIN_MODE_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h1;
	// Default sample width
	localparam int SAMPLE_WIDTH = 14;
	// Drive resume time after buffer power-down clears
	localparam int RESUME_NS = 40;
	localparam int CLK_PERIOD_NS = 4;
	localparam int RESUME_CYCLES = (RESUME_NS / CLK_PERIOD_NS > 0) ? RESUME_NS / CLK_PERIOD_NS : 1;
endpackage : adcfmt_pkg

// [verilog/adcfmt_lvds_lane.sv]
// Link-clock DDR lane: launches odd bit high half, even bit low half
`timescale 1ns/1ps
module adcfmt_lvds_lane #(
	parameter int PAIRS = 7
) (
	input wire logic lclk,
	input wire logic lresetn,
	input wire logic [2*PAIRS-1:0] word,
	output logic [PAIRS-1:0] pair_out
);
	logic [PAIRS-1:0] odd_q;
	logic [PAIRS-1:0] even_q;
	logic [PAIRS-1:0] odd_bits;
	logic [PAIRS-1:0] even_bits;

	// Split sample into even and odd bit groups
	always_comb begin
		for (int i = 0; i < PAIRS; i++) begin
			even_bits[i] = word[2*i];
			odd_bits[i] = word[2*i+1];
		end
	end

	// Odd bits change on rising edge
	always_ff @(posedge lclk or negedge lresetn) begin
		if (!lresetn) begin
			odd_q <= '0;
		end else begin
			odd_q <= odd_bits;
		end
	end

	// Even bits change on falling edge
	always_ff @(negedge lclk or negedge lresetn) begin
		if (!lresetn) begin
			even_q <= '0;
		end else begin
			even_q <= even_bits;
		end
	end

	// Clock high shows odd bits, clock low shows even bits
	assign pair_out = lclk ? odd_q : even_q;
endmodule : adcfmt_lvds_lane

// [verilog/adcfmt_top.sv]
// Output data formatter of the converter: format, saturate, LVDS or CMOS drive
// Function
// - LVDS packs two bits per pair
// - Even bits falling edge, odd rising
// - CMOS drives one bit per pin
// - Two's complement or offset binary output
// - Positive overdrive gives positive full scale
// - Negative overdrive gives negative full scale
// - Register bit or pin selects interface
// - Sample delivered with synchronised output clock
// - Buffer powerdown tristates, resumes after 40 ns
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module adcfmt_top #(
	parameter int WIDTH = adcfmt_pkg::SAMPLE_WIDTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [WIDTH-1:0] sample_in,
	input wire logic sample_valid,
	input wire logic over_pos,
	input wire logic over_neg,
	input wire logic format_select_pin,
	input wire logic interface_select_pin,
	input wire logic lclk,
	output logic [WIDTH/2-1:0] lvds_pair,
	output logic [WIDTH/2-1:0] lvds_pair_oen,
	output logic lvds_out_clock_pos,
	output logic lvds_clk_oen,
	output logic [WIDTH-1:0] cmos_data,
	output logic [WIDTH-1:0] cmos_data_oen,
	output logic cmos_out_clock,
	output logic cmos_clk_oen
);
	localparam int PAIRS = WIDTH / 2;
	localparam int CW = $clog2(adcfmt_pkg::RESUME_CYCLES + 1);
	localparam logic [CW-1:0] RESUME_CNT = CW'(adcfmt_pkg::RESUME_CYCLES);

	// Full-scale codes: offset binary max/min, two's complement max/min
	function automatic logic [WIDTH-1:0] full_scale(input logic pos, input logic twos);
		logic [WIDTH-1:0] v;
		v = pos ? {WIDTH{1'b1}} : {WIDTH{1'b0}};
		if (twos) begin
			v[WIDTH-1] = ~v[WIDTH-1];
		end
		return v;
	endfunction : full_scale

	logic [3:0] ctrl;
	logic [CW-1:0] resume_cnt;
	logic pdn_q;
	logic [1:0] fmt_sync;
	logic [1:0] ifc_sync;
	logic [WIDTH-1:0] cmos_q;
	logic cmos_clk_q;
	logic [WIDTH-1:0] word_hold;
	logic word_toggle;
	logic [2:0] lsync;
	logic [WIDTH-1:0] lword;
	logic [1:0] lrst_sync;
	logic lresetn;
	logic [1:0] l_en_sync;
	logic [1:0] l_mode_sync;

	wire apb_write = psel && penable && pwrite;
	wire addr_ok = (paddr == adcfmt_pkg::ADDR_CTRL) || (paddr == adcfmt_pkg::ADDR_STATUS);
	wire pin_mode = ctrl[adcfmt_pkg::CTRL_PIN_MODE_BIT];
	// Interface chosen by bit or pin
	wire use_cmos = pin_mode ? ifc_sync[1] : ~ctrl[adcfmt_pkg::CTRL_INTERFACE_BIT];
	// Format chosen by bit or pin
	wire twos = pin_mode ? fmt_sync[1] : ctrl[adcfmt_pkg::CTRL_FORMAT_BIT];
	wire pdn = ctrl[adcfmt_pkg::CTRL_PDN_BIT];
	// Off in the cycle that powerdown clears too, before the count is loaded
	wire outputs_on = !pdn && !pdn_q && (resume_cnt == '0);
	wire [WIDTH-1:0] converted = twos ? {~sample_in[WIDTH-1], sample_in[WIDTH-2:0]} : sample_in;
	// Saturation codes sized to variant width
	wire [WIDTH-1:0] formatted = over_pos ? full_scale(1'b1, twos) :
		over_neg ? full_scale(1'b0, twos) : converted;

	// APB: zero wait, error on unmapped address
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = (paddr == adcfmt_pkg::ADDR_CTRL) ? {28'h0000000, ctrl} :
		(paddr == adcfmt_pkg::ADDR_STATUS) ? {29'h00000000, outputs_on, twos, use_cmos} :
		32'h00000000;

	// Control register write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= adcfmt_pkg::CTRL_RESET;
		end else if (apb_write && paddr == adcfmt_pkg::ADDR_CTRL) begin
			ctrl <= pwdata[3:0];
		end
	end

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt_sync <= 2'h0;
			ifc_sync <= 2'h0;
		end else begin
			fmt_sync <= {fmt_sync[0], format_select_pin};
			ifc_sync <= {ifc_sync[0], interface_select_pin};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pdn_q <= 1'b0;
			resume_cnt <= '0;
		end else begin
			pdn_q <= pdn;
			if (pdn) begin
				resume_cnt <= '0;
			end else if (pdn_q) begin
				resume_cnt <= RESUME_CNT;
			end else if (resume_cnt != '0) begin
				resume_cnt <= resume_cnt - CW'(1);
			end
		end
	end

	// CMOS parallel word, clock low in the cycle after each sample, high otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmos_q <= '0;
			cmos_clk_q <= 1'b0;
		end else if (sample_valid) begin
			cmos_q <= formatted;
			cmos_clk_q <= 1'b0;
		end else begin
			cmos_clk_q <= 1'b1;
		end
	end

	assign cmos_data = cmos_q;
	assign cmos_out_clock = cmos_clk_q;
	// Drivers enabled low only while on and selected
	assign cmos_data_oen = {WIDTH{!(outputs_on && use_cmos)}};
	assign cmos_clk_oen = !(outputs_on && use_cmos);

	// Hold word for the link domain, toggle marks a new one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_hold <= '0;
			word_toggle <= 1'b0;
		end else if (sample_valid && !use_cmos) begin
			word_hold <= formatted;
			word_toggle <= ~word_toggle;
		end
	end

	// Link reset release synchroniser
	always_ff @(posedge lclk or negedge presetn) begin
		if (!presetn) begin
			lrst_sync <= 2'h0;
		end else begin
			lrst_sync <= {lrst_sync[0], 1'b1};
		end
	end
	assign lresetn = lrst_sync[1];

	// Toggle handshake into link domain; word stable when toggle seen
	always_ff @(posedge lclk or negedge lresetn) begin
		if (!lresetn) begin
			lsync <= 3'h0;
			lword <= '0;
			l_en_sync <= 2'h0;
			l_mode_sync <= 2'h0;
		end else begin
			lsync <= {lsync[1:0], word_toggle};
			l_en_sync <= {l_en_sync[0], outputs_on};
			l_mode_sync <= {l_mode_sync[0], use_cmos};
			if (lsync[2] != lsync[1]) begin
				lword <= word_hold;
			end
		end
	end

	// DDR lane on the link clock
	adcfmt_lvds_lane #(
		.PAIRS(PAIRS)
	) u_lane (
		.lclk(lclk),
		.lresetn(lresetn),
		.word(lword),
		.pair_out(lvds_pair)
	);

	// Output clock is the link clock
	assign lvds_out_clock_pos = lclk;
	assign lvds_pair_oen = {PAIRS{!(l_en_sync[1] && !l_mode_sync[1])}};
	assign lvds_clk_oen = !(l_en_sync[1] && !l_mode_sync[1]);

	// Positive overdrive yields positive full scale
	ovr_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
		sample_valid && over_pos |=> cmos_data == full_scale(1'b1, $past(twos)))
		else $error("positive saturation code wrong");
	// Negative overdrive yields negative full scale
	ovr_neg_a: assert property (@(posedge pclk) disable iff (!presetn)
		sample_valid && over_neg && !over_pos |=> cmos_data == full_scale(1'b0, $past(twos)))
		else $error("negative saturation code wrong");
	fmt_conv_a: assert property (@(posedge pclk) disable iff (!presetn)
		sample_valid && !over_pos && !over_neg && twos |=>
		cmos_data == {~$past(sample_in[WIDTH-1]), $past(sample_in[WIDTH-2:0])})
		else $error("twos complement conversion wrong");
	pdn_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
		pdn |-> cmos_data_oen == {WIDTH{1'b1}} && cmos_clk_oen)
		else $error("outputs driven in powerdown");
	resume_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(pdn) |-> !outputs_on [*8] ##[1:4] outputs_on)
		else $error("resume delay wrong");
	// CMOS drives when selected and on
	cmos_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		outputs_on && use_cmos |-> cmos_data_oen == '0)
		else $error("CMOS pins not driven");
	// Interface follows pin in pin mode
	pin_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		pin_mode |-> use_cmos == ifc_sync[1])
		else $error("pin interface select ignored");
	// CMOS clock low when new data launched
	clk_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
		sample_valid |=> !cmos_out_clock)
		else $error("CMOS clock not aligned to data");
	// Odd bit shown while link clock high
	ddr_odd_a: assert property (@(negedge lclk) disable iff (!lresetn)
		##1 lvds_pair[0] == lword[1] || $changed(lword))
		else $error("odd bit not on rising edge");
endmodule : adcfmt_top

// [bench/adcfmt_rx_model.sv]
// Receiver model that captures LVDS and CMOS samples
`timescale 1ns/1ps
module adcfmt_rx_model #(
	parameter int W = 14
) (
	input wire logic lclk_in,
	input wire logic [W/2-1:0] pair,
	input wire logic cmos_clk,
	input wire logic [W-1:0] cmos_in,
	output logic [W-1:0] lvds_word,
	output logic [W-1:0] cmos_word
);
	logic [W-1:0] acc = '0;
	// Capture on both clock edges
	// Mid-half sampling keeps clear of the launch edges
	always @(lclk_in) begin
		#8;
		for (int i = 0; i < W / 2; i++) begin
			acc[2 * i + (lclk_in ? 1 : 0)] = pair[i];
		end
		if (!lclk_in) lvds_word = acc;
	end
	always @(posedge cmos_clk) cmos_word <= cmos_in;
endmodule : adcfmt_rx_model

// [bench/testbench.sv]
// Testbench of the output data formatter with receiver model
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0, lclk = 1'b0, presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, lvds_out_clock_pos, lvds_clk_oen, cmos_out_clock, cmos_clk_oen;
	logic [13:0] sample_in = 14'h0000, cmos_data, cmos_data_oen, lvds_word, cmos_word;
	logic sample_valid = 1'b0, over_pos = 1'b0, over_neg = 1'b0;
	logic format_select_pin = 1'b0, interface_select_pin = 1'b0;
	logic [6:0] lvds_pair, lvds_pair_oen;
	logic [13:0] cmos_late;
	int n_mismatch = 0, n_compared = 0, n;
	// Capture CMOS data on a delayed copy of the sampling clock
	always @(posedge pclk) begin
		#2;
		cmos_late = cmos_data;
	end
	// Clocks with unrelated phases
	always #2 pclk = ~pclk;
	initial begin
		#5.3;
		forever #16 lclk = ~lclk;
	end
	adcfmt_top #(.WIDTH(14)) i_adcfmt_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sample_in(sample_in), .sample_valid(sample_valid),
		.over_pos(over_pos), .over_neg(over_neg), .format_select_pin(format_select_pin),
		.interface_select_pin(interface_select_pin), .lclk(lclk), .lvds_pair(lvds_pair),
		.lvds_pair_oen(lvds_pair_oen), .lvds_out_clock_pos(lvds_out_clock_pos),
		.lvds_clk_oen(lvds_clk_oen), .cmos_data(cmos_data), .cmos_data_oen(cmos_data_oen),
		.cmos_out_clock(cmos_out_clock), .cmos_clk_oen(cmos_clk_oen));
	adcfmt_rx_model #(.W(14)) i_adcfmt_rx_model (.lclk_in(lvds_out_clock_pos),
		.pair(lvds_pair), .cmos_clk(cmos_out_clock), .cmos_in(cmos_data),
		.lvds_word(lvds_word), .cmos_word(cmos_word));
	task automatic results;
		$display("n_mismatch=%0d n_compared=%0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 50) begin
			n_mismatch++;
			results();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One sample, with CMOS output checks when cm is set
	task automatic send(input logic [13:0] v, input logic p, input logic ng,
		input logic [13:0] exp, input logic cm);
		@(posedge pclk);
		sample_in <= v;
		over_pos <= p;
		over_neg <= ng;
		sample_valid <= 1'b1;
		@(posedge pclk);
		sample_valid <= 1'b0;
		#1;
		if (cm) begin
			check(cmos_data, exp);
			check(cmos_out_clock, 1'b0);
			@(posedge pclk);
			#1;
			check(cmos_out_clock, 1'b1);
			check(cmos_word, exp);
			check(cmos_late, exp);
		end
	endtask : send
	task automatic lvds(input logic [13:0] v, input logic [13:0] exp);
		send(v, 1'b0, 1'b0, 14'h0000, 1'b0);
		repeat (16) @(posedge lclk);
		check(lvds_word, exp);
		check({lvds_clk_oen, lvds_pair_oen}, 8'h00);
		check(lvds_out_clock_pos, lclk);
	endtask : lvds
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h00C, 32'hF, rd, err);
		check(err, 1'b1);
		apb(1'b0, adcfmt_pkg::ADDR_CTRL, 32'h0, rd, err);
		check(rd, 32'h0000_0001);
		apb(1'b0, 12'h008, 32'h0, rd, err);
		check({rd[30:0], err}, 32'h0000_0001);
		apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h0, rd, err);
		send(14'h1234, 1'b0, 1'b0, 14'h1234, 1'b1);
		send(14'h0ABC, 1'b1, 1'b0, 14'h3FFF, 1'b1);
		send(14'h3ABC, 1'b0, 1'b1, 14'h0000, 1'b1);
		check(cmos_data_oen, 14'h0000);
		apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h2, rd, err);
		send(14'h1234, 1'b0, 1'b0, 14'h3234, 1'b1);
		send(14'h0ABC, 1'b1, 1'b0, 14'h1FFF, 1'b1);
		send(14'h3ABC, 1'b0, 1'b1, 14'h2000, 1'b1);
		apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h6, rd, err);
		@(posedge pclk);
		#1;
		check({cmos_clk_oen, cmos_data_oen}, 15'h7FFF);
		apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h2, rd, err);
		for (n = 0; n < 40 && cmos_data_oen !== 14'h0000; n++) begin
			@(posedge pclk);
			#1;
		end
		check(n >= adcfmt_pkg::RESUME_CYCLES && n < 40, 1'b1);
		check(cmos_data, 14'h2000);
		interface_select_pin <= 1'b1;
		format_select_pin <= 1'b1;
		apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h8, rd, err);
		apb(1'b0, adcfmt_pkg::ADDR_STATUS, 32'h0, rd, err);
		check(rd, 32'h0000_0007);
		send(14'h1234, 1'b0, 1'b0, 14'h3234, 1'b1);
		interface_select_pin <= 1'b0;
		format_select_pin <= 1'b0;
		apb(1'b0, adcfmt_pkg::ADDR_STATUS, 32'h0, rd, err);
		check(rd, 32'h0000_0004);
		lvds(14'h2A5B, 14'h2A5B);
		apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h3, rd, err);
		lvds(14'h2A5B, 14'h0A5B);
		results();
	end
endmodule : testbench
